/* shared/sep_pkg.sv */
package sep_pkg;

    // Link pins as seen from outside the ref_clk domain
    typedef struct packed {
        logic       tck;
        logic       tms;
        logic       tdi;
        logic       trst_n;
        logic [1:0] event_n;
    } sep_pins_t;

    localparam int unsigned PIN_W = 6;

    // Synchroniser reset value: test reset low, event lines idle high
    localparam logic [PIN_W-1:0] PIN_RST = 6'h03;

    // Instruction register
    localparam int unsigned IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE   = 4'h1;
    localparam logic [IR_W-1:0] IR_BYPASS    = 4'hF;
    localparam logic [IR_W-1:0] IR_PINSCAN_A = 4'h0;
    localparam logic [IR_W-1:0] IR_PINSCAN_B = 4'h1;
    localparam logic [IR_W-1:0] IR_EMUCTRL   = 4'h8;

    // Emulation control data register
    localparam int unsigned EMU_W = 2;
    localparam logic [EMU_W-1:0] EMU_CTRL_RST = 2'h0;

    // Pod test clock and its half period in ref_clk cycles (rounded down)
    localparam real         TCK_FREQ_MHZ  = 10.368;
    localparam real         REF_FREQ_MHZ  = 100.0;
    localparam int unsigned TCK_HALF_CYC  = int'($floor(REF_FREQ_MHZ / (2.0 * TCK_FREQ_MHZ)));

    // Tap controller, one-hot
    typedef enum logic [15:0] {
        ST_TLR  = 16'h0001,
        ST_RTI  = 16'h0002,
        ST_SDR  = 16'h0004,
        ST_CDR  = 16'h0008,
        ST_SHD  = 16'h0010,
        ST_E1D  = 16'h0020,
        ST_PDR  = 16'h0040,
        ST_E2D  = 16'h0080,
        ST_UDR  = 16'h0100,
        ST_SIR  = 16'h0200,
        ST_CIR  = 16'h0400,
        ST_SHI  = 16'h0800,
        ST_E1I  = 16'h1000,
        ST_PIR  = 16'h2000,
        ST_E2I  = 16'h4000,
        ST_UIR  = 16'h8000
    } sep_state_t;

endpackage

/* rtl/sep_sync.sv */
`timescale 1ns/1ps
module sep_sync
    import sep_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Pins in, synchronised out
    input  wire logic [PIN_W-1:0] async_in,
    output logic      [PIN_W-1:0] sync_out
);

    logic [PIN_W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < PIN_W; i++) begin : g_bit
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg[i] <= PIN_RST[i];
                    sync_out[i] <= PIN_RST[i];
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

endmodule

/* rtl/sep_port.sv */
`timescale 1ns/1ps
module sep_port
    import sep_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Link pins from the pod
    input  wire sep_pins_t        pins_in,
    // Test data out
    output logic                  tdo,
    output logic                  tdo_oe,
    output logic                  test_clock_return,
    output logic                  presence_detect_line,
    // Emulation event lines, open-drain
    output logic [EMU_W-1:0]      emulation_event_o,
    output logic [EMU_W-1:0]      emulation_event_oe,
    // Core side
    input  wire logic [EMU_W-1:0] local_stop_req,
    output logic [EMU_W-1:0]      global_stop_seen,
    output logic                  test_reset_active
);

    sep_pins_t        pins_s;
    logic             tck_prev_reg;
    sep_state_t       state_reg;
    sep_state_t       state_next;
    logic [IR_W-1:0]  ir_shift_reg;
    logic [IR_W-1:0]  ir_reg;
    logic             bypass_reg;
    logic             null_reg;
    logic [EMU_W-1:0] emu_shift_reg;
    logic [EMU_W-1:0] emu_ctrl_reg;

    // Every pin passes two flops; an idle-low test reset holds the tap in reset
    sep_sync u_sync (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .async_in (pins_in),
        .sync_out (pins_s)
    );

    wire tck_rise  = pins_s.tck & ~tck_prev_reg;
    wire tck_fall  = ~pins_s.tck & tck_prev_reg;
    wire tms       = pins_s.tms;
    wire tdi       = pins_s.tdi;
    wire trst_on   = ~pins_s.trst_n;
    wire sel_null  = (ir_reg == IR_PINSCAN_A) || (ir_reg == IR_PINSCAN_B);
    wire sel_emu   = (ir_reg == IR_EMUCTRL);
    wire dr_out    = sel_emu ? emu_shift_reg[0] : (sel_null ? null_reg : bypass_reg);
    wire in_shd    = (state_reg == ST_SHD);
    wire in_shi    = (state_reg == ST_SHI);
    wire shifting  = in_shd | in_shi;
    wire tdo_next  = in_shi ? ir_shift_reg[0] : dr_out;
    wire [EMU_W-1:0] drive_low = emu_ctrl_reg | local_stop_req;

    // Tap controller next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_TLR:  state_next = tms ? ST_TLR : ST_RTI;
            ST_RTI:  state_next = tms ? ST_SDR : ST_RTI;
            ST_SDR:  state_next = tms ? ST_SIR : ST_CDR;
            ST_CDR:  state_next = tms ? ST_E1D : ST_SHD;
            ST_SHD:  state_next = tms ? ST_E1D : ST_SHD;
            ST_E1D:  state_next = tms ? ST_UDR : ST_PDR;
            ST_PDR:  state_next = tms ? ST_E2D : ST_PDR;
            ST_E2D:  state_next = tms ? ST_UDR : ST_SHD;
            ST_UDR:  state_next = tms ? ST_SDR : ST_RTI;
            ST_SIR:  state_next = tms ? ST_TLR : ST_CIR;
            ST_CIR:  state_next = tms ? ST_E1I : ST_SHI;
            ST_SHI:  state_next = tms ? ST_E1I : ST_SHI;
            ST_E1I:  state_next = tms ? ST_UIR : ST_PIR;
            ST_PIR:  state_next = tms ? ST_E2I : ST_PIR;
            ST_E2I:  state_next = tms ? ST_UIR : ST_SHI;
            ST_UIR:  state_next = tms ? ST_SDR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_prev_reg <= 1'b0;
            state_reg    <= ST_TLR;
        end else begin
            tck_prev_reg <= pins_s.tck;
            if (trst_on) begin
                state_reg <= ST_TLR;
            end else if (tck_rise) begin
                state_reg <= state_next;
            end
        end
    end

    // Instruction register path
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_shift_reg <= IR_CAPTURE;
            ir_reg       <= IR_BYPASS;
        end else if (trst_on) begin
            ir_reg <= IR_BYPASS;
        end else if (tck_rise) begin
            unique case (state_reg)
                ST_TLR:  ir_reg <= IR_BYPASS;
                ST_CIR:  ir_shift_reg <= IR_CAPTURE;
                ST_SHI:  ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
                ST_UIR:  ir_reg <= ir_shift_reg;
                default: ir_reg <= ir_reg;
            endcase
        end
    end

    // Data registers; pin scan has no cells, just one null bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bypass_reg    <= 1'b0;
            null_reg      <= 1'b0;
            emu_shift_reg <= EMU_CTRL_RST;
            emu_ctrl_reg  <= EMU_CTRL_RST;
        end else if (trst_on) begin
            emu_ctrl_reg <= EMU_CTRL_RST;
        end else if (tck_rise) begin
            unique case (state_reg)
                ST_TLR: begin
                    emu_ctrl_reg <= EMU_CTRL_RST;
                end
                ST_CDR: begin
                    bypass_reg    <= 1'b0;
                    null_reg      <= 1'b0;
                    emu_shift_reg <= ~pins_s.event_n;
                end
                ST_SHD: begin
                    bypass_reg <= tdi;
                    if (sel_null) begin
                        null_reg <= tdi;
                    end
                    if (sel_emu) begin
                        emu_shift_reg <= {tdi, emu_shift_reg[EMU_W-1:1]};
                    end
                end
                ST_UDR: begin
                    if (sel_emu) begin
                        emu_ctrl_reg <= emu_shift_reg;
                    end
                end
                default: begin
                    bypass_reg <= bypass_reg;
                end
            endcase
        end
    end

    // TDO changes on the falling edge so the next device samples it on the rise
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (trst_on) begin
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo    <= tdo_next;
            tdo_oe <= shifting;
        end
    end

    // Pin-side and core-side outputs; the return clock is a buffered copy, three cycles after the pin
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            test_clock_return    <= 1'b0;
            presence_detect_line <= 1'b1;
            emulation_event_o    <= '0;
            emulation_event_oe   <= '0;
            global_stop_seen     <= '0;
            test_reset_active    <= 1'b1;
        end else begin
            test_clock_return    <= pins_s.tck;
            presence_detect_line <= 1'b1;
            emulation_event_o    <= '0;
            emulation_event_oe   <= drive_low;
            global_stop_seen     <= ~pins_s.event_n;
            test_reset_active    <= trst_on;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_null_shift;
        tck_rise && !trst_on && state_reg == ST_SHD && sel_null;
    endsequence

    // Any fall outside Shift-IR, with test reset off and pin scan selected, hands the null bit to tdo
    sequence s_null_out;
        tck_fall && !trst_on && sel_null && !in_shi;
    endsequence

    sequence s_ir_update;
        tck_rise && !trst_on && state_reg == ST_UIR;
    endsequence

    chk_null_one_bit: assert property (s_null_shift |=> null_reg == $past(tdi))
        else $error("null register did not take tdi");

    chk_tdo_idle_off: assert property (tck_fall && !shifting |=> !tdo_oe)
        else $error("tdo driven outside shift");

    chk_tdo_null_out: assert property (s_null_out |=> tdo == $past(null_reg))
        else $error("tdo not null bit");

    chk_clock_return: assert property (test_clock_return == $past(pins_s.tck))
        else $error("return clock not a copy");

    chk_presence_high: assert property (presence_detect_line)
        else $error("presence line low");

    chk_trst_holds: assert property (trst_on |=> state_reg == ST_TLR ##1 !tdo_oe)
        else $error("test reset ignored");

    chk_event_drive: assert property (
        $rose(drive_low[0]) |=> emulation_event_oe[0] && !emulation_event_o[0])
        else $error("event line not pulled low");

    chk_event_seen: assert property (
        !pins_s.event_n[1] ##1 !pins_s.event_n[1] |-> global_stop_seen[1])
        else $error("event low not reported");

    chk_tap_escape: assert property (
        tck_rise && !trst_on && tms && state_reg == ST_SIR |=> state_reg == ST_TLR)
        else $error("tap did not reach reset");

    chk_ir_update: assert property (s_ir_update |=> ir_reg == $past(ir_shift_reg))
        else $error("instruction not updated");

endmodule

/* dv/sep_pod.sv */
`timescale 1ns/1ps
// Pod model: drives the link and resolves the open-drain event wires
module sep_pod
    import sep_pkg::*;
(
    // From the target
    input  wire logic             tdo,
    input  wire logic             tdo_oe,
    input  wire logic             ret_clk,
    input  wire logic [EMU_W-1:0] tgt_oe,
    // Link pins, resolved
    output sep_pins_t             pins,
    output logic                  stuck
);
    logic             tck = 1'b0;
    logic             tms = 1'b1;
    logic             tdi = 1'b0;
    logic             trst_n = 1'b0; // Undriven input sits at the pull-down level
    logic [EMU_W-1:0] pull = '0;

    initial stuck = 1'b0;
    // Low while either side pulls, pull-up otherwise
    assign pins = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n, event_n: ~(pull | tgt_oe)};

    // One test clock period, 125 ns in this bench
    // Next TMS/TDI after a fixed 37.5 ns, without waiting for the returned clock to fall
    // A return clock still high here means the target lost the clock
    task automatic step(input logic m, input logic d, output logic o, output logic oe,
                        output logic r);
        #37.5;
        if (ret_clk) stuck = 1'b1;
        tms = m;
        tdi = d;
        #25 tck = 1'b1;
        o = tdo;
        oe = tdo_oe;
        #50 r = ret_clk;
        #12.5 tck = 1'b0;
    endtask

    // Clock stands still between frames; data line no longer holds its value
    task automatic idle();
        tdi = ~tdi;
    endtask
endmodule

/* dv/scan_emulation_port_tb_top.sv */
`timescale 1ns/1ps
module scan_emulation_port_tb_top
    import sep_pkg::*;
;
    logic             ref_clk = 1'b0;
    logic             arst_n = 1'b0;
    logic [EMU_W-1:0] local_stop_req = '0;
    sep_pins_t        pins;
    logic             tdo, tdo_oe, ret, pres, stuck, tra;
    logic [EMU_W-1:0] ev_o, ev_oe, seen;
    logic [7:0]       got;
    int               fail_count = 0;
    int               checks = 0;

    always #5 ref_clk = ~ref_clk;

    sep_port dut (.ref_clk(ref_clk), .arst_n(arst_n), .pins_in(pins), .tdo(tdo),
        .tdo_oe(tdo_oe), .test_clock_return(ret), .presence_detect_line(pres),
        .emulation_event_o(ev_o), .emulation_event_oe(ev_oe),
        .local_stop_req(local_stop_req), .global_stop_seen(seen), .test_reset_active(tra));
    sep_pod pod (.tdo(tdo), .tdo_oe(tdo_oe), .ret_clk(ret), .tgt_oe(ev_oe), .pins(pins),
        .stuck(stuck));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] val);
        checks++;
        if (val !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, val);
        end
    endtask

    task automatic walk(input int n, input logic [3:0] m);
        logic o, oe, r;
        for (int i = 0; i < n; i++) pod.step(m[i], 1'b0, o, oe, r);
    endtask

    // LSB first; last bit leaves through exit, then update and idle
    task automatic shift(input int n, input logic [7:0] d, output logic [7:0] q);
        logic o, oe, r;
        q = '0;
        for (int i = 0; i < n; i++) begin
            pod.step(i == n - 1, d[i], o, oe, r);
            q[i] = o;
            chk("tdo_oe shifting", 8'h01, 8'(oe));
            chk("clock return", 8'h01, 8'(r));
        end
        pod.step(1'b1, 1'b0, o, oe, r);
        pod.step(1'b0, 1'b0, o, oe, r);
        pod.idle();
        wait_ref(4);
        chk("tdo_oe idle", 8'h00, 8'(tdo_oe));
        chk("clock return idle", 8'h00, 8'(ret));
    endtask

    task automatic ir_load(input logic [IR_W-1:0] code, output logic [7:0] q);
        walk(4, 4'h3);
        shift(IR_W, 8'(code), q);
    endtask

    task automatic dr(input int n, input logic [7:0] d, output logic [7:0] q);
        walk(3, 4'h1);
        shift(n, d, q);
    endtask

    task automatic wait_ref(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic test_reset();
        chk("presence in reset", 8'h01, 8'(pres));
        chk("test reset in reset", 8'h01, 8'(tra));
        chk("tdo_oe in reset", 8'h00, 8'(tdo_oe));
        arst_n = 1'b1;
        wait_ref(6);
        chk("test reset held by pull-down", 8'h01, 8'(tra));
        pod.trst_n = 1'b1;
        wait_ref(4);
        chk("test reset released", 8'h00, 8'(tra));
        chk("presence after reset", 8'h01, 8'(pres));
        $display("test reset done");
    endtask

    task automatic test_scan();
        logic [IR_W-1:0] codes [2] = '{IR_PINSCAN_A, IR_PINSCAN_B};
        walk(4, 4'hE);
        walk(1, 4'h0);
        ir_load(IR_BYPASS, got);
        chk("ir capture", 8'(IR_CAPTURE), got);
        dr(8, 8'hB5, got);
        chk("bypass one bit", 8'h6A, got);
        foreach (codes[k]) begin
            ir_load(codes[k], got);
            dr(4, 8'h0D, got);
            chk("pin scan null bit", 8'h0A, got);
        end
        $display("test scan done");
    endtask

    task automatic test_events();
        @(negedge ref_clk);
        pod.pull = 2'b10;
        ir_load(IR_EMUCTRL, got);
        dr(2, 8'h01, got);
        chk("event capture", 8'h02, got);
        chk("event drive", 8'h01, 8'(ev_oe));
        chk("event level", 8'h00, 8'(ev_o));
        chk("both lines seen", 8'h03, 8'(seen));
        pod.pull = 2'b00;
        local_stop_req = 2'b10;
        wait_ref(1);
        chk("local stop drive", 8'h03, 8'(ev_oe));
        local_stop_req = 2'b00;
        wait_ref(4);
        chk("line 0 still seen", 8'h01, 8'(seen));
        pod.trst_n = 1'b0;
        wait_ref(4);
        chk("test reset active", 8'h01, 8'(tra));
        chk("control cleared", 8'h00, 8'(ev_oe));
        $display("test events done");
    endtask

    task automatic report_and_stop();
        if (stuck) fail_count++;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        wait_ref(12);
        test_reset();
        test_scan();
        test_events();
        report_and_stop();
    end
endmodule
